/* File: common/hpp_map.vh */
// hpp_map.vh: shared constants for the host parallel port pin and address logic
// assumes inclusion by bare name from the design files; definitions only
`ifndef HPP_MAP_VH
`define HPP_MAP_VH

// access type codes on access_type_sel
`define HPP_ACC_CTRL      2'h0
`define HPP_ACC_DATA_INC  2'h1
`define HPP_ACC_ADDR      2'h2
`define HPP_ACC_DATA      2'h3

// reset values
`define HPP_ADDR_RST      32'h00000000
`define HPP_HW_RST        16'h0000

// address step of one 32-bit word, in bytes
`define HPP_ADDR_STEP     32'h00000004

// buffer depth
`define HPP_BUF_DEPTH     2

`endif

/* File: sim/hpp_mem_model.sv */
// hpp_mem_model.sv: behavioural memory engine answering fetches and taking write words
// assumes one clock with the port; stall slows both directions
`timescale 1ns/1ps
module hpp_mem_model (
    input  wire         clock,
    input  wire         rst_n,
    input  wire         stall,
    input  wire         rd_req,
    input  wire  [31:0] rd_req_addr,
    output logic        rd_word_valid,
    output logic [31:0] rd_word_data,
    output logic        wr_word_ready
);
    logic [3:0]  cnt;
    logic [31:0] addr;
    // fetch answer is the inverted address; data toggles outside valid so nothing stale passes
    always @(posedge clock) begin
        rd_word_valid <= 1'b0;
        rd_word_data  <= ~rd_word_data;
        wr_word_ready <= rst_n && !stall;
        if (!rst_n) begin
            cnt <= 4'h0;
        end else if (rd_req) begin
            cnt  <= stall ? 4'h8 : 4'h1;
            addr <= rd_req_addr;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
                rd_word_valid <= 1'b1;
                rd_word_data  <= ~addr;
            end
        end
    end
endmodule // hpp_mem_model

/* File: sim/hpp_port_bench.sv */
// hpp_port_bench.sv: self-checking bench for the host port pin and address logic
// assumes hpp_port, hpp_mem_model and the bound checker are compiled alongside
`timescale 1ns/1ps
`include "hpp_map.vh"
module hpp_port_bench;
    logic        clock, rst_n, cs_n, rnw, hwp, ds_a, ds_b, irq_set, split, asel, stall;
    logic [1:0]  acc;
    logic [15:0] hd_in;
    logic [31:0] exp_wr[$], exp_rd[$], got, q, a, b, c, d;
    wire  [15:0] hd_out, creg;
    wire  [31:0] rar, war, wdat, wadr, rqa, rdat;
    wire         oe, wait_n, irq, wv, rq, rv, wr_rdy, cwp;
    int          err_count, checks_done, cycles, seed, cw_seen;
    event        rd_ev;

    hpp_port dut_u (.clock(clock), .rst_n(rst_n), .access_type_sel(acc),
        .port_chip_select_n(cs_n), .host_read_not_write(rnw), .halfword_position(hwp),
        .address_strobe_n(1'b1), .data_strobe_a(ds_a), .data_strobe_b(ds_b),
        .host_data_bus_in(hd_in), .host_data_bus_out(hd_out), .host_data_bus_oe(oe),
        .port_wait_n(wait_n), .irq_to_host(irq), .cpu_irq_set(irq_set),
        .split_address_mode(split), .address_reg_select(asel), .port_control_reg(creg),
        .ctrl_write_pulse(cwp), .read_address_reg(rar), .write_address_reg(war),
        .wr_word_valid(wv), .wr_word_ready(wr_rdy), .wr_word_data(wdat),
        .wr_word_addr(wadr), .rd_req(rq), .rd_req_addr(rqa), .rd_word_valid(rv),
        .rd_word_data(rdat));
    hpp_mem_model mem_u (.clock(clock), .rst_n(rst_n), .stall(stall), .rd_req(rq),
        .rd_req_addr(rqa), .rd_word_valid(rv), .rd_word_data(rdat), .wr_word_ready(wr_rdy));

    // clock and a cycle ceiling well above the several hundred cycles the tests need
    initial begin clock = 1'b0; forever #5 clock = ~clock; end
    always @(posedge clock) begin
        cycles++;
        if (cwp === 1'b1) cw_seen++;
        if (cycles == 6000) begin err_count++; close_out(); end
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tick(input int n = 1);
        repeat (n) begin @(posedge clock); #1; end
    endtask
    task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin err_count++; $display("[FAIL] %s expected %h seen %h", what, e, s); end
    endtask
    task automatic chk_bit(input string what, input logic e, input logic s);
        checks_done++;
        if (s !== e) begin err_count++; $display("[FAIL] %s expected %b seen %b", what, e, s); end
    endtask
    // one halfword: pins settle, strobe falls, wait for ready, sample, strobe rises
    task automatic half(input logic [1:0] t, input logic r, input logic h, input logic [15:0] v,
                        output logic [15:0] o);
        int n;
        acc = t; rnw = r; hwp = h; hd_in = r ? ~hd_in : v;
        tick(5);
        if (r) ds_b = 1'b0; else ds_a = 1'b0;
        tick(5);
        for (n = 0; n < 200 && wait_n !== 1'b0; n++) tick();
        if (n == 200) chk_bit("ready within bound", 1'b0, wait_n);
        if (r) chk_bit("bus enable on read", 1'b1, oe);
        o = hd_out;
        ds_a = 1'b1; ds_b = 1'b1;
        tick(5);
    endtask
    task automatic cyc(input logic [1:0] t, input logic r, input logic [31:0] v,
                       output logic [31:0] o);
        half(t, r, 1'b0, v[31:16], o[31:16]);
        half(t, r, 1'b1, v[15:0], o[15:0]);
    endtask
    // write words leaving the port are matched against the oldest notes
    always @(posedge clock) if (rst_n && wv === 1'b1 && wr_rdy) begin
        chk_word("write word addr", exp_wr.pop_front(), wadr);
        chk_word("write word data", exp_wr.pop_front(), wdat);
    end
    always @(rd_ev) chk_word("read word", exp_rd.pop_front(), got);

    initial begin
        seed = 65343; cycles = 0; err_count = 0; checks_done = 0;
        rst_n = 0; cs_n = 0; rnw = 0; hwp = 0; ds_a = 1; ds_b = 1; acc = 2'h0; hd_in = 16'h0;
        irq_set = 0; split = 0; asel = 0; stall = 0;
        tick(2); rst_n = 1; tick(3);
        chk_bit("idle interrupt pin", 1'b1, irq);
        chk_bit("idle ready", 1'b0, wait_n);
        $display("test reset done");
        irq_set = 1; tick(); irq_set = 0; tick(4);
        chk_bit("interrupt raised", 1'b0, irq);
        cyc(`HPP_ACC_CTRL, 1'b0, 32'h00000002, q); tick(4);
        chk_bit("interrupt acknowledged", 1'b1, irq);
        chk_word("control value", 32'h00000002, {16'h0, creg});
        chk_word("control write pulses", 32'h1, cw_seen);
        $display("test interrupt done");
        a = $random(seed) & 32'hFFFFFFFC;
        cyc(`HPP_ACC_ADDR, 1'b0, a, q); tick(2);
        chk_word("read addr load", a, rar);
        chk_word("write addr load", a, war);
        cyc(`HPP_ACC_ADDR, 1'b1, 32'h0, q);
        chk_word("address readback", a, q);
        stall = 1; // far side stalls for 80 cycles while the write words queue up
        fork begin tick(80); stall = 0; end join_none
        for (int i = 0; i < 3; i++) begin
            d = $random(seed); exp_wr.push_back(a + 4 * i); exp_wr.push_back(d);
            cyc(`HPP_ACC_DATA_INC, 1'b0, d, q);
        end
        tick(10);
        chk_word("read addr bumped", a + 12, rar);
        chk_word("write addr bumped", a + 12, war);
        cyc(`HPP_ACC_ADDR, 1'b0, a, q);
        exp_rd.push_back(~a);
        cyc(`HPP_ACC_DATA_INC, 1'b1, 32'h0, got); ->rd_ev; tick(2);
        chk_word("read addr after read", a + 4, rar);
        chk_word("write addr after read", a + 4, war);
        $display("test single mode done");
        split = 1; asel = 1; tick(5);
        b = $random(seed) & 32'hFFFFFFFC; c = $random(seed) & 32'hFFFFFFFC;
        cyc(`HPP_ACC_ADDR, 1'b0, b, q); tick(2);
        chk_word("split read load", b, rar);
        chk_word("split write kept", a + 4, war);
        asel = 0;
        cyc(`HPP_ACC_ADDR, 1'b0, c, q); tick(2);
        chk_word("split write load", c, war);
        cyc(`HPP_ACC_ADDR, 1'b1, 32'h0, q);
        chk_word("split readback", c, q);
        exp_rd.push_back(~b);
        cyc(`HPP_ACC_DATA_INC, 1'b1, 32'h0, got); ->rd_ev; tick(2);
        chk_word("split read bumped", b + 4, rar);
        d = $random(seed); exp_wr.push_back(c); exp_wr.push_back(d);
        cyc(`HPP_ACC_DATA, 1'b0, d, q); tick(10);
        chk_word("split write held", c, war);
        $display("test split mode done");
        cs_n = 1; tick(2); ds_a = 0; tick(8);
        chk_bit("ready while deselected", 1'b0, wait_n);
        chk_bit("bus idle while deselected", 1'b0, oe);
        ds_a = 1; tick(8); cs_n = 0; tick(5);
        chk_word("regs after ignored strobe", c, war);
        chk_word("all writes seen", 32'h0, exp_wr.size());
        $display("test deselect done");
        close_out();
    end
endmodule // hpp_port_bench

/* File: sim/hpp_port_sva.sv */
// hpp_port_sva.sv: concurrent checks on the host port pins and address registers
// assumes binding to hpp_port and sight of its ports only
`timescale 1ns/1ps
module hpp_port_sva (
    input wire        clock,
    input wire        rst_n,
    input wire        port_chip_select_n,
    input wire        host_read_not_write,
    input wire        host_data_bus_oe,
    input wire        port_wait_n,
    input wire        irq_to_host,
    input wire        cpu_irq_set,
    input wire        split_address_mode,
    input wire [31:0] read_address_reg,
    input wire [31:0] write_address_reg,
    input wire        wr_word_valid,
    input wire        wr_word_ready,
    input wire [31:0] wr_word_data,
    input wire [31:0] wr_word_addr,
    input wire        rd_req,
    input wire [31:0] rd_req_addr
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // six cycles covers the synchroniser and edge detect after a deselect
    sequence s_desel; port_chip_select_n [*6]; endsequence
    property p_wait_desel; s_desel |-> !port_wait_n; endproperty
    property p_oe_desel; s_desel |-> !host_data_bus_oe; endproperty
    property p_irq; cpu_irq_set |-> ##[1:4] !irq_to_host; endproperty
    property p_single_both;
        !split_address_mode && $past(!split_address_mode)
        |-> $changed(read_address_reg) == $changed(write_address_reg);
    endproperty
    property p_dual_one;
        split_address_mode && $past(split_address_mode)
        |-> !($changed(read_address_reg) && $changed(write_address_reg));
    endproperty
    property p_rdreq; rd_req |-> rd_req_addr == read_address_reg; endproperty
    property p_wr_hold;
        wr_word_valid && !wr_word_ready
        |=> wr_word_valid && $stable({wr_word_data, wr_word_addr});
    endproperty
    property p_oe_read; host_data_bus_oe |-> $past(host_read_not_write, 4); endproperty
    a_wait_desel: assert property (p_wait_desel)
        else $error("wait output high while deselected");
    a_oe_desel: assert property (p_oe_desel)
        else $error("bus driven while deselected");
    a_irq: assert property (p_irq)
        else $error("interrupt pin not low after set");
    a_single_both: assert property (p_single_both)
        else $error("single mode address registers moved apart");
    a_dual_one: assert property (p_dual_one)
        else $error("split mode touched both address registers");
    a_rdreq: assert property (p_rdreq)
        else $error("fetch address differs from read address register");
    a_wr_hold: assert property (p_wr_hold)
        else $error("write word changed while stalled");
    a_oe_read: assert property (p_oe_read)
        else $error("bus driven during a write access");
endmodule // hpp_port_sva

bind hpp_port hpp_port_sva chk_u (.*);

/* File: src/hpp_buf2.v */
// hpp_buf2.v: two-entry buffer with valid/ready on both sides
// assumes a single clock; a stall on the drain side holds data, never drops it
`timescale 1ns/1ps
`include "hpp_map.vh"
module hpp_buf2 #(
    parameter WIDTH = 32
) (
    input  wire             clock,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:`HPP_BUF_DEPTH-1];
    reg             wr_ptr;
    reg             rd_ptr;
    reg [1:0]       count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and occupancy update; push and pop may share a cycle
    always @(posedge clock) begin
        if (!rst_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= ~wr_ptr;
            end
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push && !pop)
                count <= count + 2'h1;
            else if (pop && !push)
                count <= count - 2'h1;
        end
    end
endmodule // hpp_buf2

/* File: src/hpp_port.v */
// hpp_port.v: host-facing pin logic and read/write address registers
// assumes an asynchronous host master; memory transfer engine sits outside,
// fed by the write-word stream and answering read requests with data words
`timescale 1ns/1ps
`include "hpp_map.vh"

// What this block does
// [R1] access type captured at internal strobe falling edge selects control, address or data
// [R2] host holds chip select low to select the port
// [R3] direction sampled at strobe fall: high reads, low writes
// [R4] host marks first halfword low, second halfword high
// [R5] address strobe unused, held high by the system
// [R6] processor sets host interrupt bit; host clears by writing one
// [R7] interrupt pin is low while the host interrupt bit is set
// [R8] strobe fall captures control; write data captured on strobe rise
// [R9] data bus driven on reads only while the strobe is active
// [R10] one data bus carries addresses and data in successive transfers
// [R11] ready output low lets host finish; high means wait
// [R12] two 32-bit address registers; reads use read one, writes use write one
// [R13] split mode bit: zero shares one address, one gives independent registers
// [R14] host loads only word-aligned byte addresses
// [R15] single mode address write loads both address registers
// [R16] single mode auto-increment data cycle bumps both address registers
// [R17] single mode address read returns the read address register
// [R18] host rewrites addresses after mode change or direction change
// [R19] split mode address access hits read reg when select is one, else write reg
// [R20] select bit matters only for host address access in split mode
// [R21] split mode auto-increment bumps only its direction register after use
// [R22] access code zero selects the control register
// [R23] strobe activity is ignored while chip select is high
// [R24] ready is gated by chip select: deselect forces ready low
// [R25] host strobe, select and control inputs are synchronised before use
module hpp_port (
    input  wire        clock,
    input  wire        rst_n,
    // host pins
    input  wire [1:0]  access_type_sel,
    input  wire        port_chip_select_n,
    input  wire        host_read_not_write,
    input  wire        halfword_position,
    input  wire        address_strobe_n,
    input  wire        data_strobe_a,
    input  wire        data_strobe_b,
    input  wire [15:0] host_data_bus_in,
    output reg  [15:0] host_data_bus_out,
    output reg         host_data_bus_oe,
    output reg         port_wait_n,
    output reg         irq_to_host,
    // processor side
    input  wire        cpu_irq_set,
    input  wire        split_address_mode,
    input  wire        address_reg_select,
    output reg  [15:0] port_control_reg,
    output reg         ctrl_write_pulse,
    output reg  [31:0] read_address_reg,
    output reg  [31:0] write_address_reg,
    // write words toward the memory engine
    output reg         wr_word_valid,
    input  wire        wr_word_ready,
    output reg  [31:0] wr_word_data,
    output reg  [31:0] wr_word_addr,
    // read words from the memory engine
    output reg         rd_req,
    output reg  [31:0] rd_req_addr,
    input  wire        rd_word_valid,
    input  wire [31:0] rd_word_data
);
    // synchronised pins
    wire [1:0]  s_acc;
    wire        s_cs_n;
    wire        s_rnw;
    wire        s_hw;
    wire        s_ds_a;
    wire        s_ds_b;
    wire [15:0] s_data;

    hpp_sync #(.WIDTH(7), .INIT(7'h0F)) u_sync_ctl (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in ({access_type_sel, port_chip_select_n, host_read_not_write,
                    halfword_position, data_strobe_a, data_strobe_b}),
        .sync_out ({s_acc, s_cs_n, s_rnw, s_hw, s_ds_a, s_ds_b})
    ); // R25

    hpp_sync #(.WIDTH(16), .INIT(16'h0000)) u_sync_data (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in (host_data_bus_in),
        .sync_out (s_data)
    );

    // internal strobe: either data strobe active with chip select low;
    // strobes are taken active-low, the idle level is high
    wire strobe_now = ~(s_ds_a & s_ds_b) & ~s_cs_n; // R23
    reg  strobe_q;
    wire strobe_fall = strobe_now & ~strobe_q;
    wire strobe_rise = ~strobe_now & strobe_q;

    // latched cycle information
    reg [1:0]  cyc_acc;
    reg        cyc_rnw;
    reg        cyc_hw;
    reg [15:0] first_half;
    reg        irq_bit;
    reg        rd_pending;
    reg        rd_have;
    reg [31:0] rd_data;
    reg        buf_in_valid;
    reg [31:0] buf_in_data;
    reg [31:0] buf_in_addr;
    wire       buf_in_ready;
    wire       buf_out_valid;
    wire [63:0] buf_out_data;
    wire        head_take;

    // next word address after one word step
    function [31:0] next_addr;
        input [31:0] a;
        begin
            next_addr = a + `HPP_ADDR_STEP;
        end
    endfunction

    // halfword of a word picked by position
    function [15:0] pick_half;
        input [31:0] w;
        input        second;
        begin
            pick_half = second ? w[15:0] : w[31:16];
        end
    endfunction

    // address the host sees on an address-register read
    wire [31:0] addr_view = (split_address_mode && !address_reg_select)
                            ? write_address_reg : read_address_reg; // R17 R19 R20

    // value driven on reads, selected by the latched access type
    reg [15:0] next_out;
    always @* begin
        case (cyc_acc)
            `HPP_ACC_CTRL:    next_out = port_control_reg; // R22
            `HPP_ACC_ADDR:    next_out = pick_half(addr_view, cyc_hw); // R10
            `HPP_ACC_DATA_INC,
            `HPP_ACC_DATA:    next_out = pick_half(rd_data, cyc_hw);
            default:          next_out = `HPP_HW_RST;
        endcase
    end

    // ready: wait while a read word is outstanding or write buffer full;
    // deselect forces ready low so a chip-select strobe never hangs the host
    wire busy = (cyc_rnw && cyc_acc[0] && !rd_have) ||
                (!cyc_rnw && cyc_acc[0] && !buf_in_ready);

    // main host cycle process
    always @(posedge clock) begin
        if (!rst_n) begin
            strobe_q          <= 1'b0;
            cyc_acc           <= `HPP_ACC_CTRL;
            cyc_rnw           <= 1'b1;
            cyc_hw            <= 1'b0;
            first_half        <= `HPP_HW_RST;
            host_data_bus_out <= `HPP_HW_RST;
            host_data_bus_oe  <= 1'b0;
            port_wait_n       <= 1'b0;
            irq_to_host       <= 1'b1;
            irq_bit           <= 1'b0;
            port_control_reg  <= `HPP_HW_RST;
            ctrl_write_pulse  <= 1'b0;
            read_address_reg  <= `HPP_ADDR_RST;
            write_address_reg <= `HPP_ADDR_RST;
            rd_pending        <= 1'b0;
            rd_have           <= 1'b0;
            rd_data           <= `HPP_ADDR_RST;
            rd_req            <= 1'b0;
            rd_req_addr       <= `HPP_ADDR_RST;
            buf_in_valid      <= 1'b0;
            buf_in_data       <= `HPP_ADDR_RST;
            buf_in_addr       <= `HPP_ADDR_RST;
        end else begin
            strobe_q         <= strobe_now;
            ctrl_write_pulse <= 1'b0;
            rd_req           <= 1'b0;
            if (buf_in_valid && buf_in_ready)
                buf_in_valid <= 1'b0;

            // control capture on strobe fall
            if (strobe_fall) begin
                cyc_acc <= s_acc; // R1
                cyc_rnw <= s_rnw; // R3
                cyc_hw  <= s_hw;
                // first halfword of a data read starts the memory fetch
                if (s_rnw && s_acc[0] && !s_hw && !rd_pending && !rd_have) begin
                    rd_pending  <= 1'b1;
                    rd_req      <= 1'b1;
                    rd_req_addr <= read_address_reg; // R12
                end
            end

            if (rd_pending && rd_word_valid) begin
                rd_pending <= 1'b0;
                rd_have    <= 1'b1;
                rd_data    <= rd_word_data;
            end

            // data bus driven only on reads while strobe is active
            host_data_bus_oe  <= strobe_now && cyc_rnw && !strobe_fall; // R9
            host_data_bus_out <= next_out;
            port_wait_n       <= ~s_cs_n && strobe_now && busy; // R11 R24

            // write data and address loads on strobe rise
            if (strobe_rise && !cyc_rnw && !busy) begin // R8
                if (!cyc_hw) begin
                    first_half <= s_data;
                end else begin
                    case (cyc_acc)
                        `HPP_ACC_CTRL: begin
                            port_control_reg <= s_data;
                            ctrl_write_pulse <= 1'b1;
                            if (s_data[1])
                                irq_bit <= 1'b0; // R6
                        end
                        `HPP_ACC_ADDR: begin
                            if (!split_address_mode) begin
                                read_address_reg  <= {first_half, s_data}; // R15
                                write_address_reg <= {first_half, s_data};
                            end else if (address_reg_select) begin
                                read_address_reg  <= {first_half, s_data}; // R19
                            end else begin
                                write_address_reg <= {first_half, s_data};
                            end
                        end
                        `HPP_ACC_DATA_INC,
                        `HPP_ACC_DATA: begin
                            buf_in_valid <= 1'b1;
                            buf_in_data  <= {first_half, s_data};
                            buf_in_addr  <= write_address_reg; // R12
                            if (cyc_acc == `HPP_ACC_DATA_INC) begin
                                write_address_reg <= next_addr(write_address_reg); // R21
                                if (!split_address_mode)
                                    read_address_reg <= next_addr(read_address_reg); // R16
                            end
                        end
                        default: begin
                            first_half <= first_half;
                        end
                    endcase
                end
            end

            // second halfword of a data read finishes with the word
            if (strobe_rise && cyc_rnw && cyc_acc[0] && cyc_hw && rd_have) begin
                rd_have <= 1'b0;
                if (cyc_acc == `HPP_ACC_DATA_INC) begin
                    read_address_reg <= next_addr(read_address_reg); // R21
                    if (!split_address_mode)
                        write_address_reg <= next_addr(write_address_reg); // R16
                end
            end

            // processor set wins over a host clear in the same cycle
            if (cpu_irq_set)
                irq_bit <= 1'b1; // R6
            irq_to_host <= ~(cpu_irq_set | (irq_bit &
                           ~(strobe_rise && !cyc_rnw && cyc_hw &&
                             cyc_acc == `HPP_ACC_CTRL && s_data[1]))); // R7
        end
    end

    // write words pass a two-entry buffer so an engine stall loses nothing
    hpp_buf2 #(.WIDTH(64)) u_wbuf (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   ({buf_in_addr, buf_in_data}),
        .out_valid (buf_out_valid),
        .out_ready (head_take),
        .out_data  (buf_out_data)
    );

    // the head leaves the buffer only when the output stage is empty or being emptied,
    // so a word popped from the buffer always lands in the output register
    assign head_take = buf_out_valid && (!wr_word_valid || wr_word_ready);

    // register the buffer head so top outputs come from flip-flops;
    // stays valid until the engine accepts it
    always @(posedge clock) begin
        if (!rst_n) begin
            wr_word_valid <= 1'b0;
            wr_word_data  <= `HPP_ADDR_RST;
            wr_word_addr  <= `HPP_ADDR_RST;
        end else if (head_take) begin
            wr_word_valid <= 1'b1;
            wr_word_addr  <= buf_out_data[63:32];
            wr_word_data  <= buf_out_data[31:0];
        end else if (wr_word_ready) begin
            wr_word_valid <= 1'b0;
        end
    end
endmodule // hpp_port

/* File: src/hpp_sync.v */
// hpp_sync.v: two-stage synchroniser for a group of asynchronous levels
// assumes inputs come from the host pins, outside the clock domain
`timescale 1ns/1ps
module hpp_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             clock,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;

    // first stage is read only by the second stage
    always @(posedge clock) begin
        if (!rst_n) begin
            stage1   <= INIT;
            sync_out <= INIT;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // hpp_sync
